// File: hdl/tile_status_pkg.sv
// constants for the tile control and status register group
`default_nettype none
package tile_status_pkg;
   // register numbers
   localparam logic [7:0] REG_TILE_CONTROL   = 8'h02;
   localparam logic [7:0] REG_BOOT_STATUS    = 8'h03;
   localparam logic [7:0] REG_SECURITY       = 8'h05;
   localparam logic [7:0] REG_OSC_RUN        = 8'h06;
   localparam logic [7:0] REG_TILE_CELL_CNT  = 8'h07;
   localparam logic [7:0] REG_TILE_WIRE_CNT  = 8'h08;
   localparam logic [7:0] REG_PERIPH_CELL_CNT = 8'h09;
   localparam logic [7:0] REG_PERIPH_WIRE_CNT = 8'h0a;
   // tile control fields
   localparam int TC_DELAY_LSB   = 18;
   localparam int TC_DIV_LSB     = 9;
   localparam int TC_PORT_EN_BIT = 8;
   localparam int TC_DYN_BIT     = 5;
   localparam int TC_DIV_EN_BIT  = 4;
   localparam logic [31:0] TC_WRITE_MASK = 32'h03ff_ff30;
   localparam logic [31:0] TC_RESET      = 32'h0000_0000;
   // boot status fields
   localparam int BS_PROC_LSB    = 16;
   localparam int BS_SECBOOT_BIT = 8;
   localparam int BS_CORE1_BIT   = 5;
   localparam int BS_NOPOLL_BIT  = 4;
   localparam int BS_RAM_BIT     = 3;
   localparam int BS_JTAG_BIT    = 2;
   // security fields
   localparam int SC_LOCK_BIT      = 31;
   localparam int SC_GDBG_BIT      = 14;
   localparam int SC_MASTER_BIT    = 12;
   localparam int SC_SECTOR_LSB    = 8;
   localparam int SC_REDUND_BIT    = 7;
   localparam int SC_SECBOOT_BIT   = 5;
   localparam int SC_JTAGCFG_BIT   = 4;
   localparam int SC_JTAGDBG_BIT   = 0;
   localparam logic [31:0] SC_WRITE_MASK = 32'h8000_5fb1;
   // oscillator control fields
   localparam int OSC_CORE_BIT   = 1;
   localparam int OSC_PERIPH_BIT = 0;
   localparam int OSC_CNT_W      = 16;
endpackage
`default_nettype wire

// File: hdl/tile_control_status_regs.sv
// processor-status register group of one tile
`default_nettype none
// Functional notes
// - tile control bits 25:18 hold transmit data delay in pll cycles, reset zero
// - pll-clocked counter raises tx clock at divider field, drops at half
// - tile control bit 8 enables media ports, reset zero
// - tile control bit 4 enables pll output divider for low power, reset zero
// - bit 5 set divides only while all active threads pause; else always
// - boot status is read-only, processor number in bits 23:16
// - boot status bit 3 ram boot, bit 2 jtag boot, bits 1:0 pll pins
// - boot status bit 5 second core off, bit 4 skip otp polling
// - security register loads copy of otp security word
// - security bit 31 set blocks further software writes to that register
// - security bit 14 blocks global debug access
// - security bit 0 blocks jtag debug tap access
// - bit 12 locks all otp sectors, bits 11:8 each one, bit 7 redundancy
// - security bit 5 forces boot image from otp
// - security bit 4 blocks jtag access to pll and boot registers
// - oscillator control bit 1 runs core, bit 0 peripheral oscillators, reset stopped
// - counter registers show 16-bit value in 15:0, upper bits zero
// - oscillator counters keep counts through system reset
// - registers 7, 8, 9 show tile cell, tile wire, peripheral cell counts
// - oscillators run asynchronous to tile clock, usable as random source
// - register 0x0a shows peripheral wire count, same layout
module tile_control_status_regs
   import tile_status_pkg::*;
#(
   parameter int DELAY_W = 8,
   parameter int DIV_W   = 9
) (
   // clock and reset
   input  wire logic        mclk_i,
   input  wire logic        rst_n_i,
   input  wire logic        pll_clk_en_i,
   // processor-status access
   input  wire logic        ps_write_i,
   input  wire logic        ps_read_i,
   input  wire logic [7:0]  ps_reg_i,
   input  wire logic [31:0] ps_wdata_i,
   output logic      [31:0] ps_rdata_o,
   // boot straps and otp
   input  wire logic [7:0]  proc_number_i,
   input  wire logic [1:0]  boot_pll_pin_levels_i,
   input  wire logic        boot_from_ram_i,
   input  wire logic        boot_from_jtag_i,
   input  wire logic        second_core_powered_off_i,
   input  wire logic        skip_otp_poll_i,
   input  wire logic        otp_word_valid_i,
   input  wire logic [31:0] otp_security_word_i,
   // thread state
   input  wire logic        all_threads_paused_i,
   // ring oscillator raw toggles (asynchronous)
   input  wire logic [3:0]  osc_tick_i,
   // controls out
   output logic             media_tx_clk_o,
   output logic [DELAY_W-1:0] media_tx_delay_o,
   output logic             media_port_enable_o,
   output logic             pll_divide_active_o,
   output logic             core_osc_run_o,
   output logic             periph_osc_run_o,
   // security controls out
   output logic             global_debug_block_o,
   output logic             jtag_debug_block_o,
   output logic             otp_master_lock_o,
   output logic [3:0]       otp_sector_lock_o,
   output logic             otp_redundancy_enable_o,
   output logic             secure_boot_o,
   output logic             jtag_cfg_block_o
);

   // ============================================================
   // register state
   logic [31:0] tile_ctrl_q, tile_ctrl_d;
   logic [31:0] secur_q, secur_d;
   logic [1:0]  osc_run_q, osc_run_d;
   logic [31:0] rdata_q, rdata_d;

   // writes keep only the writable bits of each register
   // otp load wins over a software write in the same cycle
   // the lock bit only stops software, a later otp copy still lands
   // read-only and unknown numbers fall through untouched
   always_comb begin
      tile_ctrl_d = tile_ctrl_q;
      secur_d     = secur_q;
      osc_run_d   = osc_run_q;
      if (otp_word_valid_i) begin
         secur_d = otp_security_word_i & SC_WRITE_MASK;
      end
      if (ps_write_i) begin
         unique case (ps_reg_i)
            REG_TILE_CONTROL: tile_ctrl_d = ps_wdata_i & TC_WRITE_MASK;
            REG_SECURITY: begin
               if (!secur_q[SC_LOCK_BIT] && !otp_word_valid_i) begin
                  secur_d = ps_wdata_i & SC_WRITE_MASK;
               end
            end
            REG_OSC_RUN: begin
               osc_run_d = {ps_wdata_i[OSC_CORE_BIT], ps_wdata_i[OSC_PERIPH_BIT]};
            end
            default: ;
         endcase
      end
   end

   // security reads zero until the otp copy or a software write arrives
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         tile_ctrl_q <= TC_RESET;
         secur_q     <= 32'h0000_0000;
         osc_run_q   <= 2'h0;
      end else begin
         tile_ctrl_q <= tile_ctrl_d;
         secur_q     <= secur_d;
         osc_run_q   <= osc_run_d;
      end
   end

   // ============================================================
   // ring oscillator counters, not reset
   // counts hold through system reset; the declared value only seeds
   // them at power up so software never reads an unknown count
   logic [2:0]           tick_sync_q [4];
   logic [2:0]           tick_sync_d [4];
   logic [OSC_CNT_W-1:0] osc_cnt_q   [4] = '{default: '0};
   logic [OSC_CNT_W-1:0] osc_cnt_d   [4];
   logic [3:0]           tick_seen_q, tick_seen_d;

   // lanes 0 and 1 are core oscillators, lanes 2 and 3 peripheral
   function automatic logic lane_run(input int lane, input logic [1:0] run);
      if (lane < 2) begin
         lane_run = run[OSC_CORE_BIT];
      end else begin
         lane_run = run[OSC_PERIPH_BIT];
      end
   endfunction

   // raw toggles cross from the oscillator domains through three stages
   // a level change counts once, after the second and third stages agree;
   // both edges of the raw toggle count
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         tick_sync_d[i] = {tick_sync_q[i][1:0], osc_tick_i[i]};
         tick_seen_d[i] = tick_seen_q[i];
         osc_cnt_d[i]   = osc_cnt_q[i];
         if (tick_sync_q[i][2] == tick_sync_q[i][1]) begin
            tick_seen_d[i] = tick_sync_q[i][2];
            if ((tick_sync_q[i][2] != tick_seen_q[i]) && lane_run(i, osc_run_q)) begin
               osc_cnt_d[i] = osc_cnt_q[i] + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      for (int i = 0; i < 4; i++) begin
         tick_sync_q[i] <= tick_sync_d[i];
         osc_cnt_q[i]   <= osc_cnt_d[i];
      end
      tick_seen_q <= tick_seen_d;
   end

   // ============================================================
   // read path
   function automatic logic [31:0] cnt_word(input logic [OSC_CNT_W-1:0] c);
      cnt_word = {16'h0000, c};
   endfunction

   // boot status word: straps straight through, secure boot from security copy
   function automatic logic [31:0] boot_word(input logic [7:0] proc,
                                             input logic       sec_boot,
                                             input logic       core1_off,
                                             input logic       no_poll,
                                             input logic       from_ram,
                                             input logic       from_jtag,
                                             input logic [1:0] pll_pins);
      boot_word                   = 32'h0000_0000;
      boot_word[BS_PROC_LSB +: 8] = proc;
      boot_word[BS_SECBOOT_BIT]   = sec_boot;
      boot_word[BS_CORE1_BIT]     = core1_off;
      boot_word[BS_NOPOLL_BIT]    = no_poll;
      boot_word[BS_RAM_BIT]       = from_ram;
      boot_word[BS_JTAG_BIT]      = from_jtag;
      boot_word[1:0]              = pll_pins;
   endfunction

   // read data is registered and holds until the next read strobe
   // reserved bits and unknown numbers read zero
   // counters are only meaningful once the oscillators have stopped
   always_comb begin
      rdata_d = rdata_q;
      if (ps_read_i) begin
         unique case (ps_reg_i)
            REG_TILE_CONTROL:  rdata_d = tile_ctrl_q;
            REG_BOOT_STATUS:   rdata_d = boot_word(proc_number_i, secur_q[SC_SECBOOT_BIT],
               second_core_powered_off_i, skip_otp_poll_i, boot_from_ram_i,
               boot_from_jtag_i, boot_pll_pin_levels_i);
            REG_SECURITY:        rdata_d = secur_q;
            REG_OSC_RUN:         rdata_d = {30'h0, osc_run_q};
            REG_TILE_CELL_CNT:   rdata_d = cnt_word(osc_cnt_q[0]);
            REG_TILE_WIRE_CNT:   rdata_d = cnt_word(osc_cnt_q[1]);
            REG_PERIPH_CELL_CNT: rdata_d = cnt_word(osc_cnt_q[2]);
            REG_PERIPH_WIRE_CNT: rdata_d = cnt_word(osc_cnt_q[3]);
            default:             rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // ============================================================
   // media transmit clock divider, stepped on pll enable
   logic [DIV_W-1:0] div_cnt_q, div_cnt_d;
   logic             tx_clk_q, tx_clk_d;
   logic [DIV_W-1:0] div_val;
   logic             div_act_q, div_act_d;
   logic [13:0]      outs_q, outs_d;

   assign div_val = tile_ctrl_q[TC_DIV_LSB +: DIV_W];

   // counter and clock only step on the pll enable pulse; a divider
   // lowered below the count wraps at once instead of running to overflow
   // tx clock high time is half the divided period, rounded by the shift
   always_comb begin
      div_cnt_d = div_cnt_q;
      tx_clk_d  = tx_clk_q;
      if (pll_clk_en_i) begin
         if (div_cnt_q >= div_val) begin
            div_cnt_d = '0;
         end else begin
            div_cnt_d = div_cnt_q + 1'b1;
         end
         if (div_cnt_q == div_val) begin
            tx_clk_d = 1'b1;
         end else if (div_cnt_q == (div_val >> 1)) begin
            tx_clk_d = 1'b0;
         end
      end

      // static mode divides always, dynamic mode only with every thread paused
      div_act_d = tile_ctrl_q[TC_DIV_EN_BIT]
                  && (!tile_ctrl_q[TC_DYN_BIT] || all_threads_paused_i);

      // security and control copies, one cycle behind their registers
      outs_d[13]   = secur_q[SC_GDBG_BIT];
      outs_d[12]   = secur_q[SC_JTAGDBG_BIT];
      outs_d[11]   = secur_q[SC_MASTER_BIT];
      outs_d[10:7] = secur_q[SC_SECTOR_LSB +: 4];
      outs_d[6]    = secur_q[SC_REDUND_BIT];
      outs_d[5]    = secur_q[SC_SECBOOT_BIT];
      outs_d[4]    = secur_q[SC_JTAGCFG_BIT];
      outs_d[3]    = tile_ctrl_q[TC_PORT_EN_BIT];
      outs_d[2]    = osc_run_q[OSC_CORE_BIT];
      outs_d[1]    = osc_run_q[OSC_PERIPH_BIT];
      outs_d[0]    = 1'b0;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         div_cnt_q <= '0;
         tx_clk_q  <= 1'b0;
         div_act_q <= 1'b0;
         outs_q    <= 14'h0000;
      end else begin
         div_cnt_q <= div_cnt_d;
         tx_clk_q  <= tx_clk_d;
         div_act_q <= div_act_d;
         outs_q    <= outs_d;
      end
   end

   // ============================================================
   // outputs
   // every output is a flop or a fixed slice of one
   // the delay field drives straight from the tile control register
   assign ps_rdata_o              = rdata_q;
   assign media_tx_clk_o          = tx_clk_q;
   assign media_tx_delay_o        = tile_ctrl_q[TC_DELAY_LSB +: DELAY_W];
   assign pll_divide_active_o     = div_act_q;
   assign global_debug_block_o    = outs_q[13];
   assign jtag_debug_block_o      = outs_q[12];
   assign otp_master_lock_o       = outs_q[11];
   assign otp_sector_lock_o       = outs_q[10:7];
   assign otp_redundancy_enable_o = outs_q[6];
   assign secure_boot_o           = outs_q[5];
   assign jtag_cfg_block_o        = outs_q[4];
   assign media_port_enable_o     = outs_q[3];
   assign core_osc_run_o          = outs_q[2];
   assign periph_osc_run_o        = outs_q[1];

endmodule
`default_nettype wire

// File: testbench/tile_regs_properties.sv
// assertions for the tile control and status register group
`default_nettype none
module tile_regs_properties
   import tile_status_pkg::*;
#(
   parameter int DELAY_W = 8,
   parameter int DIV_W   = 9
) (
   input wire logic               mclk_i,
   input wire logic               rst_n_i,
   input wire logic               ps_write_i,
   input wire logic               ps_read_i,
   input wire logic [7:0]         ps_reg_i,
   input wire logic [31:0]        ps_wdata_i,
   input wire logic [31:0]        ps_rdata_o,
   input wire logic [7:0]         proc_number_i,
   input wire logic               otp_word_valid_i,
   input wire logic [31:0]        otp_security_word_i,
   input wire logic               all_threads_paused_i,
   input wire logic [DELAY_W-1:0] media_tx_delay_o,
   input wire logic               media_port_enable_o,
   input wire logic               pll_divide_active_o,
   input wire logic               core_osc_run_o,
   input wire logic               jtag_debug_block_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // ====
   // write not overwritten on the following edge
   sequence wr_held(logic [7:0] r);
      ps_write_i && ps_reg_i == r ##1 !(ps_write_i && ps_reg_i == r);
   endsequence
   sequence otp_held;
      otp_word_valid_i ##1 !otp_word_valid_i && !(ps_write_i && ps_reg_i == REG_SECURITY);
   endsequence
   delay_wr_a: assert property (ps_write_i && ps_reg_i == REG_TILE_CONTROL |=>
      media_tx_delay_o == $past(ps_wdata_i[25:18])) else $error("tx delay not written");
   port_en_a: assert property (wr_held(REG_TILE_CONTROL) |=>
      media_port_enable_o == $past(ps_wdata_i[8], 2)) else $error("port enable wrong");
   div_act_a: assert property (wr_held(REG_TILE_CONTROL) |=> pll_divide_active_o ==
      ($past(ps_wdata_i[4], 2) && (!$past(ps_wdata_i[5], 2) || $past(all_threads_paused_i))))
      else $error("divider active wrong");
   osc_run_a: assert property (wr_held(REG_OSC_RUN) |=>
      core_osc_run_o == $past(ps_wdata_i[1], 2)) else $error("core osc run wrong");
   otp_load_a: assert property (otp_held |=>
      jtag_debug_block_o == $past(otp_security_word_i[0], 2)) else $error("otp copy wrong");
   boot_rd_a: assert property (ps_read_i && ps_reg_i == REG_BOOT_STATUS |=>
      ps_rdata_o[23:16] == $past(proc_number_i) && ps_rdata_o[31:24] == 8'h0)
      else $error("boot status read wrong");
   tc_rsvd_a: assert property (ps_read_i && ps_reg_i == REG_TILE_CONTROL |=>
      (ps_rdata_o & ~TC_WRITE_MASK) == 32'h0) else $error("reserved bits set");
   cnt_hi_a: assert property (ps_read_i && ps_reg_i inside {[8'h07:8'h0a]} |=>
      ps_rdata_o[31:16] == 16'h0) else $error("counter upper bits set");
   unk_rd_a: assert property (ps_read_i && !(ps_reg_i inside {[8'h02:8'h03], [8'h05:8'h0a]})
      |=> ps_rdata_o == 32'h0) else $error("unknown read not zero");
   rd_hold_a: assert property (!ps_read_i |=> $stable(ps_rdata_o))
      else $error("read data moved");
endmodule
bind tile_control_status_regs tile_regs_properties #(.DELAY_W(DELAY_W), .DIV_W(DIV_W))
   tile_regs_properties_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ps_write_i(ps_write_i),
   .ps_read_i(ps_read_i), .ps_reg_i(ps_reg_i), .ps_wdata_i(ps_wdata_i), .ps_rdata_o(ps_rdata_o),
   .proc_number_i(proc_number_i), .otp_word_valid_i(otp_word_valid_i),
   .otp_security_word_i(otp_security_word_i), .all_threads_paused_i(all_threads_paused_i),
   .media_tx_delay_o(media_tx_delay_o), .media_port_enable_o(media_port_enable_o),
   .pll_divide_active_o(pll_divide_active_o), .core_osc_run_o(core_osc_run_o),
   .jtag_debug_block_o(jtag_debug_block_o));
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench for the tile control and status register group
`default_nettype none
module tb
   import tile_status_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, pll_clk_en_i = 1'b0, ps_write_i = 1'b0, ps_read_i = 1'b0;
   logic [7:0] ps_reg_i = 8'h0, proc_number_i = 8'h5a;
   logic [31:0] ps_wdata_i = 32'h0, otp_security_word_i = 32'h0, ps_rdata_o, d;
   logic [1:0] boot_pll_pin_levels_i = 2'b10;
   logic boot_from_ram_i = 1'b1, boot_from_jtag_i = 1'b0, second_core_powered_off_i = 1'b1;
   logic skip_otp_poll_i = 1'b0, otp_word_valid_i = 1'b0, all_threads_paused_i = 1'b0;
   logic [3:0] osc_tick_i = 4'h0, otp_sector_lock_o;
   logic [7:0] media_tx_delay_o;
   logic media_tx_clk_o, media_port_enable_o, pll_divide_active_o, core_osc_run_o;
   logic periph_osc_run_o, global_debug_block_o, jtag_debug_block_o, otp_master_lock_o;
   logic otp_redundancy_enable_o, secure_boot_o, jtag_cfg_block_o;
   logic [15:0] base [4];
   int n_mismatch = 0;
   int compares = 0;
   tile_control_status_regs tile_control_status_regs_inst (
      .mclk_i                    (mclk_i),
      .rst_n_i                   (rst_n_i),
      .pll_clk_en_i              (pll_clk_en_i),
      .ps_write_i                (ps_write_i),
      .ps_read_i                 (ps_read_i),
      .ps_reg_i                  (ps_reg_i),
      .ps_wdata_i                (ps_wdata_i),
      .ps_rdata_o                (ps_rdata_o),
      .proc_number_i             (proc_number_i),
      .boot_pll_pin_levels_i     (boot_pll_pin_levels_i),
      .boot_from_ram_i           (boot_from_ram_i),
      .boot_from_jtag_i          (boot_from_jtag_i),
      .second_core_powered_off_i (second_core_powered_off_i),
      .skip_otp_poll_i           (skip_otp_poll_i),
      .otp_word_valid_i          (otp_word_valid_i),
      .otp_security_word_i       (otp_security_word_i),
      .all_threads_paused_i      (all_threads_paused_i),
      .osc_tick_i                (osc_tick_i),
      .media_tx_clk_o            (media_tx_clk_o),
      .media_tx_delay_o          (media_tx_delay_o),
      .media_port_enable_o       (media_port_enable_o),
      .pll_divide_active_o       (pll_divide_active_o),
      .core_osc_run_o            (core_osc_run_o),
      .periph_osc_run_o          (periph_osc_run_o),
      .global_debug_block_o      (global_debug_block_o),
      .jtag_debug_block_o        (jtag_debug_block_o),
      .otp_master_lock_o         (otp_master_lock_o),
      .otp_sector_lock_o         (otp_sector_lock_o),
      .otp_redundancy_enable_o   (otp_redundancy_enable_o),
      .secure_boot_o             (secure_boot_o),
      .jtag_cfg_block_o          (jtag_cfg_block_o)
   );
   always #2.5 mclk_i = ~mclk_i;
   // ====
   // bus cycles and comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] r, input logic [31:0] v);
      @(posedge mclk_i);
      ps_write_i <= 1'b1;
      ps_reg_i <= r;
      ps_wdata_i <= v;
      @(posedge mclk_i);
      ps_write_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] r);
      @(posedge mclk_i);
      ps_read_i <= 1'b1;
      ps_reg_i <= r;
      @(posedge mclk_i);
      ps_read_i <= 1'b0;
      #1 d = ps_rdata_o;
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ====
   // scenarios
   task automatic t_reset;
      rd(REG_TILE_CONTROL);
      chk(d, 32'h0);
      rd(REG_OSC_RUN);
      chk(d, 32'h0);
      chk(32'({media_port_enable_o, pll_divide_active_o}), 32'h0);
      rd(8'h04);
      chk(d, 32'h0);
   endtask
   task automatic t_boot;
      wr(REG_BOOT_STATUS, 32'hffff_ffff);
      rd(REG_BOOT_STATUS);
      chk(d, 32'h005a_002a);
      @(posedge mclk_i);
      {boot_from_ram_i, boot_from_jtag_i, second_core_powered_off_i} <= 3'b010;
      {skip_otp_poll_i, boot_pll_pin_levels_i} <= 3'b101;
      rd(REG_BOOT_STATUS);
      chk(d, 32'h005a_0015);
   endtask
   task automatic t_ctrl;
      wr(REG_TILE_CONTROL, 32'hffff_ffff);
      rd(REG_TILE_CONTROL);
      chk(d, 32'h03ff_ff30);
      chk(32'({media_tx_delay_o, media_port_enable_o, pll_divide_active_o}), 32'h3fe);
      all_threads_paused_i <= 1'b1;
      repeat (2) @(posedge mclk_i);
      #1 chk(32'(pll_divide_active_o), 32'h1);
      @(posedge mclk_i);
      all_threads_paused_i <= 1'b0;
      wr(REG_TILE_CONTROL, 32'h0000_0010);
      repeat (2) @(posedge mclk_i);
      #1 chk(32'({media_port_enable_o, pll_divide_active_o}), 32'h1);
   endtask
   task automatic t_txclk;
      int highs;
      highs = 0;
      wr(REG_TILE_CONTROL, 32'h0000_0600);
      pll_clk_en_i <= 1'b1;
      repeat (8) @(posedge mclk_i);
      repeat (40) begin
         @(posedge mclk_i);
         #1 if (media_tx_clk_o === 1'b1) highs++;
      end
      chk(32'(highs), 32'd20);
      @(posedge mclk_i);
      pll_clk_en_i <= 1'b0;
   endtask
   task automatic t_sec;
      @(posedge mclk_i);
      otp_security_word_i <= 32'h4000_5fb3;
      otp_word_valid_i <= 1'b1;
      @(posedge mclk_i);
      otp_word_valid_i <= 1'b0;
      rd(REG_SECURITY);
      chk(d, 32'h0000_5fb1);
      chk(32'({global_debug_block_o, jtag_debug_block_o, otp_master_lock_o, otp_sector_lock_o,
         otp_redundancy_enable_o, secure_boot_o, jtag_cfg_block_o}), 32'h3ff);
      wr(REG_SECURITY, 32'h0000_0001);
      rd(REG_SECURITY);
      chk(d, 32'h1);
      wr(REG_SECURITY, 32'h8000_0000);
      wr(REG_SECURITY, 32'h0000_4031);
      rd(REG_SECURITY);
      chk(d, 32'h8000_0000);
      chk(32'({secure_boot_o, jtag_cfg_block_o, jtag_debug_block_o}), 32'h0);
   endtask
   task automatic t_osc;
      for (int k = 0; k < 4; k++) begin
         rd(REG_TILE_CELL_CNT + 8'(k));
         base[k] = d[15:0];
      end
      wr(REG_OSC_RUN, 32'h3);
      rd(REG_OSC_RUN);
      chk(32'({d[1:0], core_osc_run_o, periph_osc_run_o}), 32'hf);
      for (int j = 1; j <= 8; j++) begin
         repeat (5) @(posedge mclk_i);
         osc_tick_i <= osc_tick_i ^ {j <= 8, j <= 6, j <= 4, j <= 2};
      end
      repeat (6) @(posedge mclk_i);
      wr(REG_OSC_RUN, 32'h0);
      repeat (2) @(posedge mclk_i);
      osc_tick_i <= ~osc_tick_i;
      repeat (12) @(posedge mclk_i);
      for (int p = 0; p < 2; p++) begin
         if (p == 1) begin
            @(posedge mclk_i);
            rst_n_i <= 1'b0;
            repeat (2) @(posedge mclk_i);
            rst_n_i <= 1'b1;
         end
         for (int k = 0; k < 4; k++) begin
            rd(REG_TILE_CELL_CNT + 8'(k));
            chk(d, {16'h0, base[k] + 16'(2 * (k + 1))});
         end
      end
   endtask
   initial begin
      repeat (5) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_boot();
      t_ctrl();
      t_txclk();
      t_sec();
      t_osc();
      test_done();
   end
endmodule
`default_nettype wire
